/* disc_servo_pkg.sv */
package disc_servo_pkg;

  // ----------------------------------------------------------------
  // register map (plain port, word addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ctrl_addr   = 4'h0;
  localparam logic [3:0] jump_addr   = 4'h1;
  localparam logic [3:0] status_addr = 4'h2;
  localparam logic [3:0] pclk_addr   = 4'h3;

  // control register fields
  localparam int ctrl_focus_on_bit   = 0;
  localparam int ctrl_gain_high_bit  = 1;
  localparam int ctrl_spindle_en_bit = 2;
  localparam int ctrl_tone_curve_disc_flag_bit       = 3;
  localparam logic [7:0] ctrl_reset  = 8'h00;

  // jump register fields: bit0 start, bit1 outward, bits 15:8 accel cycles,
  // bits 23:16 decel cycles
  localparam int jump_start_bit = 0;
  localparam int jump_out_bit   = 1;
  localparam int jump_acc_lsb   = 8;
  localparam int jump_dec_lsb   = 16;

  // status register fields
  localparam int st_rough_bit  = 0;
  localparam int st_lock_bit   = 1;
  localparam int st_sync_bit   = 2;
  localparam int st_jump_bit   = 3;

  // playback clock divider reset value (half period, cycles of clk)
  localparam logic [7:0] pclk_div_reset = 8'h01;

  // spindle error window for rough servo, in frame-phase units
  localparam logic [7:0] rough_window = 8'h10;

  // track jump state machine
  typedef enum logic [2:0] {
    jump_idle  = 3'b001,
    jump_accel = 3'b010,
    jump_decel = 3'b100
  } jump_state_t;

endpackage

/* pair_drive.sv */
`timescale 1ns/1ps
// drives one complementary pair of request lines from separate up and down requests
module pair_drive (
  input  wire logic clk,    // system clock
  input  wire logic rst,    // async reset, active high
  input  wire logic req_up, // request positive line
  input  wire logic req_dn, // request negative line
  output logic      pos_o,  // positive output
  output logic      neg_o   // negative output
);

  // ----------------------------------------------------------------
  // registered pair, never both high
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else begin
      pos_o <= req_up & ~req_dn;
      neg_o <= req_dn & ~req_up;
    end
  end

endmodule

/* disc_servo_status_outputs.sv */
// Function
// - speed-up request drives positive motor line high, slow-down the negative one.
// - servo-mode monitor high in rough servo, low in phase control.
// - focus output low turns focus servo on, high keeps it off.
// - when locked, playback clock appears on the monitor output.
// - frame sync match high only while detected and internal sync agree.
// - tracking gain output low requests higher gain, high is normal.
// - positive jump line accelerates outward jumps, decelerates inward jumps.
// - negative jump line accelerates inward jumps, decelerates outward jumps.
// - de-emphasis monitor high while the disc is flagged pre-emphasised.
// - spare test output stays low.
// - channel bit and its complement drive two outputs.
`timescale 1ns/1ps
module disc_servo_status_outputs #(
  parameter int acc_w = 8 // width of jump phase counters
) (
  input  wire logic        clk,                    // system clock, 100 MHz
  input  wire logic        rst,                    // async reset, active high
  input  wire logic [3:0]  reg_addr,               // register word address
  input  wire logic [31:0] reg_wdata,              // write data
  input  wire logic        reg_wr,                 // write strobe
  input  wire logic        reg_rd,                 // read strobe
  output logic      [31:0] reg_rdata,              // read data, cycle after strobe
  input  wire logic [7:0]  phase_err,              // signed frame phase error
  input  wire logic        pll_locked,             // bit clock phase lock
  input  wire logic        sync_detected,          // sync found in channel stream
  input  wire logic        sync_internal,          // internal frame sync strobe
  input  wire logic        tone_curve_disc_flag_flag,              // subcode pre-emphasis flag
  input  wire logic        channel_bit,            // sliced channel bit
  output logic             spindle_speed_up,       // spindle accelerate
  output logic             spindle_slow_down,      // spindle decelerate
  output logic             rough_servo_mon,        // high in rough servo
  output logic             focus_loop_on_n,        // low: focus servo on
  output logic             playback_clock_monitor, // playback clock monitor
  output logic             frame_sync_match,       // sync agreement
  output logic             tracking_gain_high_n,   // low: high gain
  output logic             jump_pulse_pos,         // jump line positive
  output logic             jump_pulse_neg,         // jump line negative
  output logic             tone_curve_disc_flag,   // de-emphasis disc
  output logic             spare_test_output,      // test output, low
  output logic             channel_bit_out,        // channel bit
  output logic             channel_bit_out_n       // complemented channel bit
);

  initial begin
    if (acc_w < 1 || acc_w > 8) $error("acc_w must be 1..8");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [23:0] jump_cfg_r;
  logic [7:0]  pclk_div_r;
  logic        jump_start;
  logic        rough_r;
  logic        busy;

  // control register written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl_r <= disc_servo_pkg::ctrl_reset;
    else if (reg_wr && reg_addr == disc_servo_pkg::ctrl_addr) ctrl_r <= reg_wdata[7:0];
  end

  // jump configuration; start bit is a write-only pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) jump_cfg_r <= 24'h000000;
    else if (reg_wr && reg_addr == disc_servo_pkg::jump_addr) jump_cfg_r <= reg_wdata[23:0];
  end

  assign jump_start = reg_wr && reg_addr == disc_servo_pkg::jump_addr
                      && reg_wdata[disc_servo_pkg::jump_start_bit];

  // playback clock divider setting, zero treated as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pclk_div_r <= disc_servo_pkg::pclk_div_reset;
    else if (reg_wr && reg_addr == disc_servo_pkg::pclk_addr) pclk_div_r <= reg_wdata[7:0];
  end

  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        disc_servo_pkg::ctrl_addr:   reg_rdata <= {24'h000000, ctrl_r};
        disc_servo_pkg::jump_addr:   reg_rdata <= {8'h00, jump_cfg_r[23:1], 1'b0};
        disc_servo_pkg::status_addr: reg_rdata <= {28'h0000000, busy, frame_sync_match,
                                                   pll_locked, rough_r};
        disc_servo_pkg::pclk_addr:   reg_rdata <= {24'h000000, pclk_div_r};
        default:                     reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // spindle speed control
  // ----------------------------------------------------------------
  logic       spin_en;
  logic [7:0] err_mag;
  logic       spin_up;
  logic       spin_dn;

  assign spin_en = ctrl_r[disc_servo_pkg::ctrl_spindle_en_bit];
  assign err_mag = phase_err[7] ? 8'(-phase_err) : phase_err;
  // positive error means disc too slow
  assign spin_up = spin_en && !phase_err[7] && phase_err != 8'h00;
  assign spin_dn = spin_en && phase_err[7];

  // rough servo while unlocked or error outside window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rough_r <= 1'b1;
    else rough_r <= !pll_locked || err_mag > disc_servo_pkg::rough_window;
  end

  assign rough_servo_mon = rough_r;

  pair_drive u_spindle (
    .clk    (clk),
    .rst    (rst),
    .req_up (spin_up),
    .req_dn (spin_dn),
    .pos_o  (spindle_speed_up),
    .neg_o  (spindle_slow_down)
  );

  // ----------------------------------------------------------------
  // focus, gain, de-emphasis, sync and test outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      focus_loop_on_n      <= 1'b1;
      tracking_gain_high_n <= 1'b1;
      tone_curve_disc_flag <= 1'b0;
      frame_sync_match     <= 1'b0;
      spare_test_output    <= 1'b0;
    end else begin
      focus_loop_on_n      <= ~ctrl_r[disc_servo_pkg::ctrl_focus_on_bit];
      tracking_gain_high_n <= ~ctrl_r[disc_servo_pkg::ctrl_gain_high_bit];
      tone_curve_disc_flag <= tone_curve_disc_flag_flag | ctrl_r[disc_servo_pkg::ctrl_tone_curve_disc_flag_bit];
      frame_sync_match     <= sync_detected & sync_internal;
      spare_test_output    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // channel bit outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_bit_out   <= 1'b0;
      channel_bit_out_n <= 1'b1;
    end else begin
      channel_bit_out   <= channel_bit;
      channel_bit_out_n <= ~channel_bit;
    end
  end

  // ----------------------------------------------------------------
  // playback clock monitor
  // ----------------------------------------------------------------
  logic [7:0] pclk_cnt_r;
  logic       pclk_r;

  // divided clock runs only while locked, held low otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pclk_cnt_r <= 8'h00;
      pclk_r     <= 1'b0;
    end else if (!pll_locked) begin
      pclk_cnt_r <= 8'h00;
      pclk_r     <= 1'b0;
    end else if (pclk_cnt_r + 8'h01 >= pclk_div_r) begin
      pclk_cnt_r <= 8'h00;
      pclk_r     <= ~pclk_r;
    end else begin
      pclk_cnt_r <= pclk_cnt_r + 8'h01;
    end
  end

  assign playback_clock_monitor = pclk_r;

  // ----------------------------------------------------------------
  // track jump sequencer
  // ----------------------------------------------------------------
  disc_servo_pkg::jump_state_t jst_r;
  logic [acc_w-1:0] jcnt_r;
  logic             outward_r;
  logic             jp_up;
  logic             jp_dn;

  // accelerate for the programmed count then decelerate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jst_r     <= disc_servo_pkg::jump_idle;
      jcnt_r    <= '0;
      outward_r <= 1'b0;
    end else begin
      case (jst_r)
        disc_servo_pkg::jump_idle: begin
          if (jump_start && reg_wdata[disc_servo_pkg::jump_acc_lsb +: acc_w] != '0) begin
            jst_r     <= disc_servo_pkg::jump_accel;
            jcnt_r    <= reg_wdata[disc_servo_pkg::jump_acc_lsb +: acc_w];
            outward_r <= reg_wdata[disc_servo_pkg::jump_out_bit];
          end
        end
        disc_servo_pkg::jump_accel: begin
          if (jcnt_r == acc_w'(1)) begin
            if (jump_cfg_r[disc_servo_pkg::jump_dec_lsb +: acc_w] == '0) begin
              jst_r <= disc_servo_pkg::jump_idle;
            end else begin
              jst_r  <= disc_servo_pkg::jump_decel;
              jcnt_r <= jump_cfg_r[disc_servo_pkg::jump_dec_lsb +: acc_w];
            end
          end else begin
            jcnt_r <= jcnt_r - acc_w'(1);
          end
        end
        disc_servo_pkg::jump_decel: begin
          if (jcnt_r == acc_w'(1)) jst_r <= disc_servo_pkg::jump_idle;
          else jcnt_r <= jcnt_r - acc_w'(1);
        end
        default: jst_r <= disc_servo_pkg::jump_idle;
      endcase
    end
  end

  assign busy  = jst_r != disc_servo_pkg::jump_idle;
  assign jp_up = (jst_r == disc_servo_pkg::jump_accel &&  outward_r) ||
                 (jst_r == disc_servo_pkg::jump_decel && !outward_r);
  assign jp_dn = (jst_r == disc_servo_pkg::jump_accel && !outward_r) ||
                 (jst_r == disc_servo_pkg::jump_decel &&  outward_r);

  pair_drive u_jump (
    .clk    (clk),
    .rst    (rst),
    .req_up (jp_up),
    .req_dn (jp_dn),
    .pos_o  (jump_pulse_pos),
    .neg_o  (jump_pulse_neg)
  );

endmodule

/* disc_servo_asserts.sv */
`timescale 1ns/1ps
module disc_servo_asserts (
  input wire logic       clk,                    // clock
  input wire logic       rst,                    // reset
  input wire logic [7:0] phase_err,              // phase error
  input wire logic       pll_locked,             // lock
  input wire logic       sync_detected,          // found sync
  input wire logic       sync_internal,          // own sync
  input wire logic       tone_curve_disc_flag_flag,              // emphasis flag
  input wire logic       channel_bit,            // sliced bit
  input wire logic       spindle_speed_up,       // accelerate
  input wire logic       spindle_slow_down,      // decelerate
  input wire logic       rough_servo_mon,        // rough servo
  input wire logic       playback_clock_monitor, // clock monitor
  input wire logic       frame_sync_match,       // sync match
  input wire logic       jump_pulse_pos,         // jump positive
  input wire logic       jump_pulse_neg,         // jump negative
  input wire logic       tone_curve_disc_flag,   // emphasis monitor
  input wire logic       spare_test_output,      // test line
  input wire logic       channel_bit_out,        // bit out
  input wire logic       channel_bit_out_n       // bit out inverted
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // output relations
  // ----------------------------------------------------------------
  a_speed_pair: assert property (!(spindle_speed_up && spindle_slow_down))
    else $error("both spindle lines high");
  a_jump_pair: assert property (!(jump_pulse_pos && jump_pulse_neg))
    else $error("both jump lines high");
  a_spindle_idle: assert property ((phase_err == 8'h00)[*3] |-> !spindle_speed_up && !spindle_slow_down)
    else $error("spindle driven with no error");
  a_sync_hit: assert property (sync_detected && sync_internal |=> frame_sync_match)
    else $error("sync match missing");
  a_sync_miss: assert property (!(sync_detected && sync_internal) |=> !frame_sync_match)
    else $error("sync match without agreement");
  a_test_low: assert property (!spare_test_output)
    else $error("test output high");
  a_chan_high: assert property (channel_bit |=> channel_bit_out && !channel_bit_out_n)
    else $error("channel pair wrong for one");
  a_chan_low: assert property (!channel_bit |=> !channel_bit_out && channel_bit_out_n)
    else $error("channel pair wrong for zero");
  a_pclk_off: assert property (!pll_locked |=> !playback_clock_monitor)
    else $error("clock monitor runs unlocked");
  a_rough_unlock: assert property ((!pll_locked)[*3] |-> rough_servo_mon)
    else $error("phase control while unlocked");
  a_tone_flag: assert property (tone_curve_disc_flag_flag |=> tone_curve_disc_flag)
    else $error("emphasis monitor low");
endmodule

bind disc_servo_status_outputs disc_servo_asserts chk_u (
  .clk, .rst, .phase_err, .pll_locked, .sync_detected, .sync_internal, .tone_curve_disc_flag_flag,
  .channel_bit, .spindle_speed_up, .spindle_slow_down, .rough_servo_mon,
  .playback_clock_monitor, .frame_sync_match, .jump_pulse_pos, .jump_pulse_neg,
  .tone_curve_disc_flag, .spare_test_output, .channel_bit_out, .channel_bit_out_n
);

/* pickup_frontend_model.sv */
`timescale 1ns/1ps
// sliced channel stream from the pickup, a bit pattern that changes often
module pickup_frontend_model (
  input  wire logic clk,        // clock
  input  wire logic rst,        // reset
  output logic      channel_bit // sliced bit
);
  logic [7:0] pat_r;

  // rotate a fixed pattern so both levels and runs appear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pat_r <= 8'hb4;
    end else begin
      pat_r <= {pat_r[0], pat_r[7:1]};
    end
  end
  assign channel_bit = pat_r[0];
endmodule

/* disc_servo_status_outputs_tb.sv */
`timescale 1ns/1ps
module disc_servo_status_outputs_tb;
  logic        clk, rst, reg_wr, reg_rd, pll_locked, sync_detected, sync_internal, tone_curve_disc_flag_flag;
  logic        channel_bit, spindle_speed_up, spindle_slow_down, rough_servo_mon;
  logic        focus_loop_on_n, playback_clock_monitor, frame_sync_match, tracking_gain_high_n;
  logic        jump_pulse_pos, jump_pulse_neg, tone_curve_disc_flag, spare_test_output;
  logic        channel_bit_out, channel_bit_out_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  phase_err;
  logic [7:0]  errs [6] = '{8'h05, 8'hfb, 8'h10, 8'h11, 8'hf0, 8'hef};
  logic [2:0]  exps [6] = '{3'b100, 3'b010, 3'b100, 3'b101, 3'b010, 3'b011};
  int          fail_count, tests_run, np, nn, first, n;

  disc_servo_status_outputs dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .phase_err, .pll_locked, .sync_detected, .sync_internal, .tone_curve_disc_flag_flag,
    .channel_bit, .spindle_speed_up, .spindle_slow_down, .rough_servo_mon, .focus_loop_on_n,
    .playback_clock_monitor, .frame_sync_match, .tracking_gain_high_n, .jump_pulse_pos,
    .jump_pulse_neg, .tone_curve_disc_flag, .spare_test_output, .channel_bit_out,
    .channel_bit_out_n);
  pickup_frontend_model fe_u (.clk, .rst, .channel_bit);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    tests_run++;
    if (a !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, a);
    end
  endtask
  // keep holds the strobe up for a write that follows with no gap
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input bit keep = 1'b0);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    if (!keep) begin
      reg_wr <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(nm, e, reg_rdata);
  endtask
  task automatic wait_mon(input logic v);
    n = 0;
    while (playback_clock_monitor !== v && n < 50) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 2'b00, 4'h0, 32'h0};
    {pll_locked, sync_detected, sync_internal, tone_curve_disc_flag_flag, phase_err} = 12'h000;
    repeat (6) @(posedge clk);
    chk("reset outs", 9'h1c0, {focus_loop_on_n, tracking_gain_high_n, rough_servo_mon,
      spindle_speed_up, spindle_slow_down, jump_pulse_pos, jump_pulse_neg,
      spare_test_output, tone_curve_disc_flag});
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h3, 32'h1, "pclk reset");
    rd(4'hf, 32'h0, "unmapped");
    wr(4'h0, 32'hf);
    repeat (3) @(posedge clk);
    chk("ctrl on", 3'b001, {focus_loop_on_n, tracking_gain_high_n, tone_curve_disc_flag});
    rd(4'h0, 32'hf, "ctrl");
    wr(4'h0, 32'h4);
    tone_curve_disc_flag_flag <= 1'b1;
    pll_locked <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ctrl off", 3'b111, {focus_loop_on_n, tracking_gain_high_n, tone_curve_disc_flag});
    tone_curve_disc_flag_flag <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      phase_err <= errs[i];
      repeat (4) @(posedge clk);
      chk("spindle", exps[i], {spindle_speed_up, spindle_slow_down, rough_servo_mon});
    end
    wr(4'h0, 32'h0);
    phase_err <= 8'h05;
    {sync_detected, sync_internal} <= 2'b11;
    repeat (4) @(posedge clk);
    chk("spindle off", 3'b000, {spindle_speed_up, spindle_slow_down, tone_curve_disc_flag});
    rd(4'h2, 32'h6, "status");
    wr(4'h3, 32'h3);
    wait_mon(1'b0);
    wait_mon(1'b1);
    wait_mon(1'b0);
    chk("pclk half", 32'd3, n);
    for (int k = 0; k < 2; k++) begin
      {np, nn, first} = 0;
      wr(4'h1, 32'h020301 | (k << 1), 1'b1);
      wr(4'h1, 32'h020303 & ~(k << 1));
      repeat (12) begin
        @(posedge clk);
        np += jump_pulse_pos;
        nn += jump_pulse_neg;
        if (first == 0) begin
          first = jump_pulse_pos ? 1 : (jump_pulse_neg ? 2 : 0);
        end
      end
      chk("jump pos", k ? 3 : 2, np);
      chk("jump neg", k ? 2 : 3, nn);
      chk("jump first", k ? 1 : 2, first);
    end
    rd(4'h1, 32'h00020300, "jump cfg");
    rd(4'h2, 32'h00000006, "status idle");
    stop_test();
  end
endmodule
